//--- rtl/ptc_pkg.sv
// Function
// - continuous adjust applies rate each tick
// - continuous adjust bit, RW, resets zero
// - enable bit starts/stops counter, resets zero
// - reset bit clears time, self-clears
// - 3-bit phase field, 8ns sub-cycles
// - phase codes 0..4 map 0..32 ns
// - nanosecond high word, RW, resets zero
// - nanosecond low word, RW, resets zero
// - seconds high word, RW, resets zero
// - read command snapshots running time coherently
// - load command loads running time
// - direction flag: one adds, zero subtracts
// - seconds low word, RW, resets zero
package ptc_pkg;

  // Clock and time base
  localparam int CLK_MHZ = 125;
  localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
  localparam int TB_PERIOD_NS = 40;
  localparam int PHASE_STEPS = TB_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [2:0] PHASE_LAST = 3'(PHASE_STEPS - 1);
  localparam logic [5:0] TICK_NS = 6'(TB_PERIOD_NS);
  localparam logic [31:0] NS_PER_SEC = 32'h3B9A_CA00;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_CTRL = 16'h0500;
  localparam logic [15:0] IDX_PHASE = 16'h0502;
  localparam logic [15:0] IDX_NS_HI = 16'h0504;
  localparam logic [15:0] IDX_NS_LO = 16'h0506;
  localparam logic [15:0] IDX_SEC_HI = 16'h0508;
  localparam logic [15:0] IDX_SEC_LO = 16'h050A;
  localparam logic [15:0] IDX_RATE_HI = 16'h050C;
  localparam logic [15:0] IDX_RATE_LO = 16'h050E;

  // Control field positions
  localparam int CTRL_RESET_BIT = 0;
  localparam int CTRL_ENABLE_BIT = 1;
  localparam int CTRL_CONT_BIT = 2;
  localparam int CTRL_LOAD_BIT = 3;
  localparam int CTRL_READ_BIT = 4;
  // Rate high word field positions
  localparam int RATE_DIR_BIT = 15;
  localparam int RATE_HI_W = 14;
  localparam int FRAC_W = 30;

  // Reset values
  localparam logic [2:0] PHASE_RST = 3'h0;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [29:0] RATE_RST = 30'h0000_0000;

  // Running time value
  typedef struct packed {
    logic [31:0] sec;
    logic [31:0] ns;
  } ptc_time_t;

  // Rate adjustment settings
  typedef struct packed {
    logic adj;
    logic dir;
    logic [FRAC_W-1:0] rate;
  } ptc_rate_t;

  // Bus slave states
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } ptc_bus_st_t;

  // Byte address of a register index
  function automatic logic [15:0] ptc_byte_adr(input logic [15:0] idx);
    return {idx[13:0], 2'b00};
  endfunction

endpackage

//--- rtl/ptc_tick_gen.sv
`timescale 1ns/1ns
module ptc_tick_gen (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic enable_i,
  input wire logic clear_i,
  input wire logic load_i,
  input wire logic [2:0] load_phase_i,
  // Phase and time-base tick
  output logic [2:0] phase_o,
  output logic tick_o
);
  import ptc_pkg::*;

  logic [2:0] phase_q;

  // Phase walks 0..4 at 125 MHz, so one wrap is a 25 MHz tick
  // phase sub-cycle counter
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      phase_q <= PHASE_RST;
    end else if (load_i) begin
      phase_q <= load_phase_i;
    end else if (enable_i) begin
      phase_q <= (phase_q >= PHASE_LAST) ? PHASE_RST : phase_q + 3'h1;
    end
  end

  // Invalid loaded codes also wrap, so the counter recovers
  assign tick_o = enable_i && !clear_i && !load_i && (phase_q >= PHASE_LAST);
  assign phase_o = phase_q;

endmodule // ptc_tick_gen

//--- rtl/ptc_time_step.sv
`timescale 1ns/1ns
module ptc_time_step (
  // Current time
  input ptc_pkg::ptc_time_t cur_i,
  input wire logic [29:0] frac_i,
  input ptc_pkg::ptc_rate_t rate_i,
  // Time after one tick
  output ptc_pkg::ptc_time_t nxt_o,
  output logic [29:0] frac_o
);
  import ptc_pkg::*;

  logic [30:0] frac_sum;
  logic [5:0] step_ns;
  logic [32:0] ns_sum;

  // Fraction accumulator with carry or borrow into nanoseconds
  always_comb begin
    frac_sum = {1'b0, frac_i};
    step_ns = TICK_NS;
    if (rate_i.adj) begin
      if (rate_i.dir) begin
        frac_sum = {1'b0, frac_i} + {1'b0, rate_i.rate};
        step_ns = TICK_NS + {5'h00, frac_sum[30]};
      end else begin
        frac_sum = {1'b0, frac_i} - {1'b0, rate_i.rate};
        step_ns = TICK_NS - {5'h00, frac_sum[30]};
      end
    end
    frac_o = frac_sum[29:0];
  end

  // Nanosecond wrap with seconds carry
  always_comb begin
    ns_sum = {1'b0, cur_i.ns} + {27'h000_0000, step_ns};
    nxt_o.sec = cur_i.sec;
    nxt_o.ns = ns_sum[31:0];
    if (ns_sum >= {1'b0, NS_PER_SEC}) begin
      nxt_o.ns = 32'(ns_sum - {1'b0, NS_PER_SEC});
      nxt_o.sec = cur_i.sec + 32'h0000_0001;
    end
  end

endmodule // ptc_time_step

//--- rtl/ptc_clock.sv
`timescale 1ns/1ns
module ptc_clock (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Running time
  output ptc_pkg::ptc_time_t time_o,
  output logic [2:0] phase_o,
  output logic clk_run_o
);
  import ptc_pkg::*;

  // Bus state
  ptc_bus_st_t bus_q;
  ptc_bus_st_t bus_d;
  logic req;
  logic wr_go;
  logic [31:0] rd_d;
  logic [31:0] rd_q;

  // Control bits
  logic en_q;
  logic cont_q;
  logic clr_pend_q;
  logic load_pend_q;
  logic read_pend_q;

  // Software-side time words and rate
  logic [2:0] sh_phase_q;
  logic [15:0] sh_ns_hi_q;
  logic [15:0] sh_ns_lo_q;
  logic [15:0] sh_sec_hi_q;
  logic [15:0] sh_sec_lo_q;
  ptc_time_t sh_time;
  logic rate_dir_q;
  logic [13:0] rate_hi_q;
  logic [15:0] rate_lo_q;
  logic [29:0] rate_q;
  ptc_rate_t rate_cfg;
  logic ctrl_wr;

  // Running time
  ptc_time_t time_q;
  logic [29:0] frac_q;
  ptc_time_t time_nxt;
  logic [29:0] frac_nxt;
  logic [2:0] phase;
  logic tick;

  // True when the request addresses the register at index idx
  function automatic logic hit(input logic [15:0] adr, input logic [15:0] idx);
    return adr == ptc_byte_adr(idx);
  endfunction

  // Merge the two low byte lanes into a 16-bit word
  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [31:0] dat,
    input logic [3:0] sel
  );
    logic [15:0] res;
    res = old;
    if (sel[0]) begin
      res[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      res[15:8] = dat[15:8];
    end
    return res;
  endfunction

  // A request is live while cycle and strobe are both high
  assign req = wb_cyc_i && wb_stb_i;

  // Writes land on the edge where the master samples ack
  assign wr_go = (bus_q == BUS_ACK) && req && wb_we_i;

  // Control write on the low byte lane; control bits and commands share it
  assign ctrl_wr = wr_go && hit(wb_adr_i, IDX_CTRL) && wb_sel_i[0];

  // Bus state: one cycle of ack per request, then idle again
  always_comb begin
    case (bus_q)
      BUS_IDLE: begin
        bus_d = req ? BUS_ACK : BUS_IDLE;
      end
      BUS_ACK: begin
        bus_d = BUS_IDLE;
      end
      default: begin
        bus_d = BUS_IDLE;
      end
    endcase
  end

  // Bus state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_q <= BUS_IDLE;
    end else begin
      bus_q <= bus_d;
    end
  end

  assign wb_ack_o = (bus_q == BUS_ACK);

  // Read mux; unmapped addresses read zero and still get ack
  always_comb begin
    rd_d = 32'h0000_0000;
    if (hit(wb_adr_i, IDX_CTRL)) begin
      rd_d[CTRL_ENABLE_BIT] = en_q;
      rd_d[CTRL_CONT_BIT] = cont_q;
    end else if (hit(wb_adr_i, IDX_PHASE)) begin
      rd_d[2:0] = sh_phase_q;
    end else if (hit(wb_adr_i, IDX_NS_HI)) begin
      rd_d[15:0] = sh_ns_hi_q;
    end else if (hit(wb_adr_i, IDX_NS_LO)) begin
      rd_d[15:0] = sh_ns_lo_q;
    end else if (hit(wb_adr_i, IDX_SEC_HI)) begin
      rd_d[15:0] = sh_sec_hi_q;
    end else if (hit(wb_adr_i, IDX_SEC_LO)) begin
      rd_d[15:0] = sh_sec_lo_q;
    end else if (hit(wb_adr_i, IDX_RATE_HI)) begin
      rd_d[RATE_DIR_BIT] = rate_dir_q;
      rd_d[RATE_HI_W-1:0] = rate_q[29:16];
    end else if (hit(wb_adr_i, IDX_RATE_LO)) begin
      rd_d[15:0] = rate_q[15:0];
    end
  end

  // Read data captured as the request arrives, held through ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_q <= 32'h0000_0000;
    end else if (bus_q == BUS_IDLE && req) begin
      rd_q <= rd_d;
    end
  end

  assign wb_dat_o = rd_q;

  // Clock enable; cleared by reset, so time does not advance until software starts it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= 1'b0;
    end else if (ctrl_wr) begin
      en_q <= wb_dat_i[CTRL_ENABLE_BIT];
    end
  end

  // Continuous adjustment bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cont_q <= 1'b0;
    end else if (ctrl_wr) begin
      cont_q <= wb_dat_i[CTRL_CONT_BIT];
    end
  end

  // Reset command; a one-cycle pulse is what makes the bit self-clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clr_pend_q <= 1'b0;
    end else begin
      clr_pend_q <= ctrl_wr && wb_dat_i[CTRL_RESET_BIT];
    end
  end

  // Load command pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_pend_q <= 1'b0;
    end else begin
      load_pend_q <= ctrl_wr && wb_dat_i[CTRL_LOAD_BIT];
    end
  end

  // Read command pulse; it trails the ack, so it never meets a word write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      read_pend_q <= 1'b0;
    end else begin
      read_pend_q <= ctrl_wr && wb_dat_i[CTRL_READ_BIT];
    end
  end

  // Phase word: the snapshot wins, but a pulse never meets a write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_phase_q <= PHASE_RST;
    end else if (read_pend_q) begin
      sh_phase_q <= phase;
    end else if (wr_go && hit(wb_adr_i, IDX_PHASE) && wb_sel_i[0]) begin
      sh_phase_q <= wb_dat_i[2:0];
    end
  end

  // Upper nanosecond word; all four words snapshot on the same edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_ns_hi_q <= WORD_RST;
    end else if (read_pend_q) begin
      sh_ns_hi_q <= time_q.ns[31:16];
    end else if (wr_go && hit(wb_adr_i, IDX_NS_HI)) begin
      sh_ns_hi_q <= merge16(sh_ns_hi_q, wb_dat_i, wb_sel_i);
    end
  end

  // Lower nanosecond word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_ns_lo_q <= WORD_RST;
    end else if (read_pend_q) begin
      sh_ns_lo_q <= time_q.ns[15:0];
    end else if (wr_go && hit(wb_adr_i, IDX_NS_LO)) begin
      sh_ns_lo_q <= merge16(sh_ns_lo_q, wb_dat_i, wb_sel_i);
    end
  end

  // Upper seconds word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_sec_hi_q <= WORD_RST;
    end else if (read_pend_q) begin
      sh_sec_hi_q <= time_q.sec[31:16];
    end else if (wr_go && hit(wb_adr_i, IDX_SEC_HI)) begin
      sh_sec_hi_q <= merge16(sh_sec_hi_q, wb_dat_i, wb_sel_i);
    end
  end

  // Lower seconds word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_sec_lo_q <= WORD_RST;
    end else if (read_pend_q) begin
      sh_sec_lo_q <= time_q.sec[15:0];
    end else if (wr_go && hit(wb_adr_i, IDX_SEC_LO)) begin
      sh_sec_lo_q <= merge16(sh_sec_lo_q, wb_dat_i, wb_sel_i);
    end
  end

  // Software words as one time value for the load command
  assign sh_time = '{sec: {sh_sec_hi_q, sh_sec_lo_q}, ns: {sh_ns_hi_q, sh_ns_lo_q}};

  // Rate direction flag in the top bit of the high rate word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rate_dir_q <= 1'b0;
    end else if (wr_go && hit(wb_adr_i, IDX_RATE_HI) && wb_sel_i[1]) begin
      rate_dir_q <= wb_dat_i[RATE_DIR_BIT];
    end
  end

  // High rate bits; bit 14 of the word is not kept and reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rate_hi_q <= RATE_RST[29:16];
    end else if (wr_go && hit(wb_adr_i, IDX_RATE_HI)) begin
      if (wb_sel_i[1]) begin
        rate_hi_q[13:8] <= wb_dat_i[13:8];
      end
      if (wb_sel_i[0]) begin
        rate_hi_q[7:0] <= wb_dat_i[7:0];
      end
    end
  end

  // Low rate bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rate_lo_q <= RATE_RST[15:0];
    end else if (wr_go && hit(wb_adr_i, IDX_RATE_LO)) begin
      rate_lo_q <= merge16(rate_lo_q, wb_dat_i, wb_sel_i);
    end
  end

  // Fraction of a nanosecond added or taken away per tick
  assign rate_q = {rate_hi_q, rate_lo_q};

  assign rate_cfg = '{adj: cont_q, dir: rate_dir_q, rate: rate_q};

  // Sub-cycle phase and 25 MHz tick
  ptc_tick_gen u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(en_q),
    .clear_i(clr_pend_q),
    .load_i(load_pend_q),
    .load_phase_i(sh_phase_q),
    .phase_o(phase),
    .tick_o(tick)
  );

  // Next time after one tick
  ptc_time_step u_step (
    .cur_i(time_q),
    .frac_i(frac_q),
    .rate_i(rate_cfg),
    .nxt_o(time_nxt),
    .frac_o(frac_nxt)
  );

  // Running time: reset over load over advance
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      time_q <= '0;
      frac_q <= RATE_RST;
    end else if (clr_pend_q) begin
      time_q <= '0;
      frac_q <= RATE_RST;
    end else if (load_pend_q) begin
      time_q <= sh_time;
      frac_q <= RATE_RST;
    end else if (tick) begin
      time_q <= time_nxt;
      frac_q <= frac_nxt;
    end
  end

  // Outputs for the stamp and trigger units; time and phase advance only while enabled, but load and reset commands move them when stopped
  assign time_o = time_q;
  assign phase_o = phase;
  assign clk_run_o = en_q;

endmodule // ptc_clock

//--- bench/ptc_clock_checker.sv
`timescale 1ns/1ns
module ptc_clock_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Time
  input ptc_pkg::ptc_time_t time_o,
  input wire logic [2:0] phase_o,
  input wire logic clk_run_o
);
  import ptc_pkg::*;
  logic tick;
  // The edge after an ack may carry a command pulse, so the phase and time properties skip it
  assign tick = clk_run_o && phase_o == 3'h4;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_ack_one: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held over one cycle");
  chk_ack_lat: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  chk_dat_hi: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  chk_phase_inc:
    assert property (clk_run_o && phase_o < 3'h4 && !$past(wb_ack_o)
      |=> phase_o == $past(phase_o) + 3'h1)
    else $error("phase did not step");
  chk_phase_wrap:
    assert property (tick && !$past(wb_ack_o) |=> phase_o == 3'h0)
    else $error("phase did not wrap after 32 ns step");
  chk_time_hold:
    assert property (!clk_run_o && !$past(wb_ack_o) |=> $stable(time_o))
    else $error("time moved while stopped");
  chk_time_step:
    assert property (clk_run_o && phase_o < 3'h4 && !$past(wb_ack_o) |=> $stable(time_o))
    else $error("time moved between ticks");
  chk_sec_carry:
    assert property (tick && !$past(wb_ack_o) && time_o.ns >= NS_PER_SEC - 32'd38
      && time_o.ns < NS_PER_SEC
      |=> time_o.sec == $past(time_o.sec) + 32'd1 && time_o.ns < NS_PER_SEC)
    else $error("seconds carry missing");
endmodule // ptc_clock_checker

bind ptc_clock ptc_clock_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .time_o(time_o),
  .phase_o(phase_o), .clk_run_o(clk_run_o));

//--- bench/tb_ptc_clock.sv
`timescale 1ns/1ns
module tb_ptc_clock;
  import ptc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [15:0] wb_adr_i = 16'h0000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  ptc_time_t time_o;
  logic [2:0] phase_o;
  logic clk_run_o;
  logic [15:0] rd;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;

  ptc_clock uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .time_o(time_o), .phase_o(phase_o),
    .clk_run_o(clk_run_o));

  // 125 MHz clock
  initial begin
    forever #4 clk_i = ~clk_i;
  end

  // Hang guard; a clean run needs far fewer cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail = n_fail + 1;
      final_report();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One classic cycle; read data is taken at the ack edge only
  task automatic bus(input logic [15:0] idx, input logic we, input logic [15:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx[13:0], 2'b00};
    wb_sel_i <= 4'h3;
    wb_dat_i <= {16'h0000, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rd = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic rchk(input logic [15:0] idx, input logic [15:0] exp);
    bus(idx, 1'b0, 16'h0000);
    check({16'h0000, rd}, {16'h0000, exp});
  endtask

  // Every register starts cleared, the clock stopped
  task automatic t_reset_values();
    logic [15:0] idx [8] = '{IDX_CTRL, IDX_PHASE, IDX_NS_HI, IDX_NS_LO, IDX_SEC_HI,
      IDX_SEC_LO, IDX_RATE_HI, IDX_RATE_LO};
    for (int i = 0; i < 8; i++) begin
      rchk(idx[i], 16'h0000);
    end
    check({31'h0, clk_run_o}, 32'h0000_0000);
  endtask

  // Reserved phase bits drop; an unmapped write is lost
  task automatic t_regs();
    bus(IDX_PHASE, 1'b1, 16'hFFFC);
    rchk(IDX_PHASE, 16'h0004);
    bus(16'h0520, 1'b1, 16'hFFFF);
    rchk(16'h0520, 16'h0000);
  endtask

  // Load while stopped, snapshot back, then run across a second boundary
  task automatic t_load_snap();
    int n;
    bus(IDX_PHASE, 1'b1, 16'h0000);
    bus(IDX_NS_HI, 1'b1, 16'h3B9A);
    bus(IDX_NS_LO, 1'b1, 16'hC9EC);
    bus(IDX_SEC_HI, 1'b1, 16'h0001);
    bus(IDX_SEC_LO, 1'b1, 16'h0002);
    rchk(IDX_SEC_HI, 16'h0001);
    bus(IDX_CTRL, 1'b1, 16'h0008);
    repeat (3) @(posedge clk_i);
    check(time_o.ns, 32'h3B9A_C9EC);
    check(time_o.sec, 32'h0001_0002);
    bus(IDX_NS_LO, 1'b1, 16'h0000);
    bus(IDX_SEC_HI, 1'b1, 16'h0000);
    bus(IDX_CTRL, 1'b1, 16'h0010);
    rchk(IDX_NS_LO, 16'hC9EC);
    rchk(IDX_SEC_HI, 16'h0001);
    rchk(IDX_CTRL, 16'h0000);
    bus(IDX_CTRL, 1'b1, 16'h0002);
    n = 0;
    while (time_o.sec === 32'h0001_0002 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    check(time_o.sec, 32'h0001_0003);
    check(time_o.ns, 32'h0000_0014);
  endtask

  // Self-clearing reset zeroes the running time
  task automatic t_reset_cmd();
    bus(IDX_CTRL, 1'b1, 16'h0001);
    repeat (2) @(posedge clk_i);
    check(time_o.ns, 32'h0000_0000);
    check(time_o.sec, 32'h0000_0000);
    check({29'h0, phase_o}, 32'h0000_0000);
    rchk(IDX_CTRL, 16'h0000);
  endtask

  // Half a nanosecond per tick, added or taken away
  task automatic t_rate(input logic dir);
    int k;
    bus(IDX_RATE_HI, 1'b1, {dir, 15'h2000});
    bus(IDX_CTRL, 1'b1, 16'h0001);
    bus(IDX_CTRL, 1'b1, 16'h0006);
    rchk(IDX_CTRL, 16'h0006);
    check({31'h0, clk_run_o}, 32'h0000_0001);
    rchk(IDX_RATE_HI, {dir, 15'h2000});
    repeat (50) @(posedge clk_i);
    bus(IDX_CTRL, 1'b1, 16'h0000);
    // A tick may still land on the disabling edge; let it settle first
    repeat (2) @(posedge clk_i);
    k = dir ? int'(time_o.ns) / 40 : (int'(time_o.ns) + 39) / 40;
    check(32'(k > 5), 32'h0000_0001);
    check(time_o.ns, 32'(dir ? 40 * k + k / 2 : 40 * k - (k + 1) / 2));
  endtask

  task automatic final_report();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_values();
    t_regs();
    t_load_snap();
    t_reset_cmd();
    t_rate(1'b1);
    t_rate(1'b0);
    final_report();
  end
endmodule // tb_ptc_clock
